// *** verilog/shutdown_pkg.sv ***
// Constants, field layouts and state types for the shutdown sequencer.
// Assumes a single core clock at the rate given below.
`default_nettype none
package shutdown_pkg;

    localparam int unsigned      CLK_FREQ_HZ         = 250_000_000;
    localparam int unsigned      EMERG_CUT_MS        = 3200;
    localparam longint unsigned  EMERG_CUT_CYCLES    = longint'(EMERG_CUT_MS) * CLK_FREQ_HZ / 1000;
    localparam int unsigned      START_WINDOW_S      = 15;
    localparam longint unsigned  START_WINDOW_CYCLES = longint'(START_WINDOW_S) * CLK_FREQ_HZ;
    localparam logic [31:0]      SAVE_CYCLE_LIMIT    = 32'h000186a0;
    localparam logic [31:0]      SYNC_LATENCY        = 32'h00000003;

    localparam logic [7:0]       CTRL_OFS            = 8'h00;
    localparam logic [7:0]       STATUS_OFS          = 8'h04;
    localparam logic [7:0]       SAVE_COUNT_OFS      = 8'h08;

    localparam int unsigned      CTRL_ALERT_SET_BIT  = 0;
    localparam int unsigned      CTRL_POWER_DOWN_BIT = 1;
    localparam int unsigned      STAT_STATE_LSB      = 0;
    localparam int unsigned      STAT_SUPPLY_BIT     = 4;
    localparam int unsigned      STAT_WINDOW_BIT     = 5;
    localparam int unsigned      STAT_EMERG_BIT      = 6;
    localparam int unsigned      STAT_ECALL_BIT      = 7;
    localparam int unsigned      STAT_BAT_LSB        = 8;
    localparam int unsigned      STAT_BRD_LSB        = 12;
    localparam int unsigned      STAT_SAVED_BIT      = 16;
    localparam int unsigned      STAT_LIMIT_BIT      = 17;

    localparam logic [2:0]       LVL_NORMAL          = 3'h0;
    localparam logic [2:0]       LVL_OVER_WARN       = 3'h1;
    localparam logic [2:0]       LVL_OVER_CRIT       = 3'h2;
    localparam logic [2:0]       LVL_UNDER_CRIT      = 3'h6;
    localparam logic [2:0]       LVL_UNDER_WARN      = 3'h7;

    typedef enum logic [2:0] {
        ST_RUN, ST_ACK, ST_OK, ST_LOGOFF, ST_SAVE, ST_NOTICE, ST_OFF
    } seq_e;

    typedef enum logic [2:0] {
        MSG_POWER_DOWN_ACK, MSG_OK, MSG_SHUTDOWN_NOTICE, MSG_BATTERY_ALERT, MSG_BOARD_ALERT
    } msg_kind_e;

    typedef struct packed {
        msg_kind_e  kind;
        logic [2:0] level;
    } msg_s;

    typedef struct packed {
        logic primary_rx_oe;
        logic primary_cts_oe;
        logic primary_carrier_oe;
        logic primary_dsr_oe;
        logic primary_ring_oe;
        logic secondary_rx_oe;
        logic secondary_cts_oe;
    } pin_oe_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        seq_e        fsm;
        logic        sync1;
        logic        sync2;
        logic [31:0] emerg_cnt;
        logic [31:0] start_cnt;
        logic        start_win;
        logic        alert_setting;
        logic [2:0]  bat_rep;
        logic [2:0]  brd_rep;
        logic        data_saved;
        logic [31:0] save_cnt;
        logic        msg_valid;
        msg_s        msg;
        logic [31:0] rdata;
        logic        logoff_req;
        logic        save_req;
        logic        supply_en;
        logic        rtc_only;
        logic        wdog_out;
        logic        pullup_en;
        pin_oe_s     pin_oe;
    } state_s;

    localparam state_s STATE_RESET = '{
        fsm: ST_RUN, sync1: 1'b1, sync2: 1'b1, emerg_cnt: 32'h0, start_cnt: 32'h0,
        start_win: 1'b1, alert_setting: 1'b0, bat_rep: LVL_NORMAL, brd_rep: LVL_NORMAL,
        data_saved: 1'b0, save_cnt: 32'h0, msg_valid: 1'b0,
        msg: '{kind: MSG_OK, level: LVL_NORMAL}, rdata: 32'h0, logoff_req: 1'b0,
        save_req: 1'b0, supply_en: 1'b1, rtc_only: 1'b0, wdog_out: 1'b0, pullup_en: 1'b1,
        pin_oe: 7'h7f
    };

endpackage : shutdown_pkg
`default_nettype wire

// *** verilog/module_shutdown_control.sv ***
// Shutdown sequencer: commanded power-down, emergency cut and thermal shutdown.
// Assumes sensor levels, call state and handshakes come from logic on core_clk;
// only the emergency-off pin is asynchronous and is synchronised here.
//
// Overview of operation
// - Command logs off, saves, leaves only clock
// - Emit acknowledge, OK, then shutdown notice
// - Notice only after save; off promptly
// - Logic supply low only when off
// - Off: emergency pin and serial outputs float
// - Watchdog pulses flow; active while reset high
// - Grounded pin blocks watchdog; supplies cut
// - Critical temperature or undervoltage: orderly shutdown
// - Alert on every range change if enabled
// - Warnings: setting 1 always, else 15 s
// - Critical alerts always shown, then shutdown
// - Separate battery and board levels reported
// - Emergency call: alerts continue, no thermal shutdown
// - Call end: still critical means off
// - Each orderly shutdown saves; status flags 100000 cycles
`timescale 1ns/10ps
`default_nettype none
module module_shutdown_control #(
    parameter logic [31:0] EMERG_CUT_CYCLES_P    = 32'(shutdown_pkg::EMERG_CUT_CYCLES),
    parameter logic [31:0] START_WINDOW_CYCLES_P = 32'(shutdown_pkg::START_WINDOW_CYCLES)
) (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    input  wire shutdown_pkg::reg_req_s reg_req,
    output logic [31:0]                 reg_rdata,
    input  wire logic                   emergency_off_n,
    output logic                        emergency_off_pullup_en,
    input  wire logic                   wdog_pulse,
    output logic                        supply_wdog_pulse,
    input  wire logic [2:0]             battery_temp_level,
    input  wire logic [2:0]             board_temp_level,
    input  wire logic                   emergency_call_active,
    input  wire logic                   undervoltage_detect,
    output logic                        logoff_req,
    input  wire logic                   logoff_done,
    output logic                        save_req,
    input  wire logic                   save_done,
    output logic                        msg_valid,
    output shutdown_pkg::msg_s          msg,
    output logic                        logic_supply_en,
    output logic                        internal_reset_n,
    output logic                        rtc_only_mode,
    output shutdown_pkg::pin_oe_s       pin_oe
);

    shutdown_pkg::state_s q;
    shutdown_pkg::state_s d;

    logic wr_ctrl;
    logic wr_pd;
    logic emerg_cut;
    logic bat_diff;
    logic brd_diff;
    logic alert_slot;
    logic crit_armed;
    logic auto_trigger;

    function automatic logic is_crit(input logic [2:0] lvl);
        return (lvl == shutdown_pkg::LVL_OVER_CRIT) || (lvl == shutdown_pkg::LVL_UNDER_CRIT);
    endfunction : is_crit

    function automatic logic presentable(input logic [2:0] lvl, input logic setting, input logic window);
        return is_crit(lvl) || setting || window;
    endfunction : presentable

    always_comb begin
        d            = q;
        d.msg_valid  = 1'b0;
        d.rdata      = 32'h0;
        wr_ctrl      = reg_req.wr && (reg_req.addr == shutdown_pkg::CTRL_OFS);
        wr_pd        = wr_ctrl && reg_req.wdata[shutdown_pkg::CTRL_POWER_DOWN_BIT];

        // Two-stage synchroniser; only the second stage is looked at
        d.sync1      = emergency_off_n;
        d.sync2      = q.sync1;

        // Pin-low counter, cleared on release
        if (q.sync2) begin
            d.emerg_cnt = 32'h0;
        end else if (q.emerg_cnt != 32'hffffffff) begin
            d.emerg_cnt = q.emerg_cnt + 32'h1;
        end
        // Threshold trimmed by sync and register delay so the cut lands inside the limit
        emerg_cut    = !q.sync2 && (q.emerg_cnt >= (EMERG_CUT_CYCLES_P - shutdown_pkg::SYNC_LATENCY));

        // Start-up presentation window
        if (q.start_win) begin
            if (q.start_cnt >= (START_WINDOW_CYCLES_P - 32'h1)) begin
                d.start_win = 1'b0;
            end else begin
                d.start_cnt = q.start_cnt + 32'h1;
            end
        end

        if (wr_ctrl && (q.fsm != shutdown_pkg::ST_OFF)) begin
            d.alert_setting = reg_req.wdata[shutdown_pkg::CTRL_ALERT_SET_BIT];
        end

        // One alert per cycle, battery first; board waits a cycle on a tie
        bat_diff     = battery_temp_level != q.bat_rep;
        brd_diff     = board_temp_level != q.brd_rep;
        alert_slot   = (q.fsm == shutdown_pkg::ST_RUN) || (q.fsm == shutdown_pkg::ST_LOGOFF) ||
                       (q.fsm == shutdown_pkg::ST_SAVE);
        if (alert_slot && bat_diff) begin
            d.bat_rep   = battery_temp_level;
            d.msg_valid = presentable(battery_temp_level, q.alert_setting, q.start_win);
            d.msg.kind  = shutdown_pkg::MSG_BATTERY_ALERT;
            d.msg.level = battery_temp_level;
        end else if (alert_slot && brd_diff) begin
            d.brd_rep   = board_temp_level;
            d.msg_valid = presentable(board_temp_level, q.alert_setting, q.start_win);
            d.msg.kind  = shutdown_pkg::MSG_BOARD_ALERT;
            d.msg.level = board_temp_level;
        end

        // Shutdown only after the critical level has been reported
        crit_armed   = (is_crit(q.bat_rep) || is_crit(q.brd_rep)) && !bat_diff && !brd_diff &&
                       !emergency_call_active;
        auto_trigger = crit_armed || undervoltage_detect;

        unique case (q.fsm)
            shutdown_pkg::ST_RUN: begin
                if (wr_pd) begin
                    d.fsm = shutdown_pkg::ST_ACK;
                end else if (auto_trigger) begin
                    d.fsm = shutdown_pkg::ST_LOGOFF;
                end
            end
            shutdown_pkg::ST_ACK: begin
                d.msg_valid = 1'b1;
                d.msg.kind  = shutdown_pkg::MSG_POWER_DOWN_ACK;
                d.msg.level = shutdown_pkg::LVL_NORMAL;
                d.fsm       = shutdown_pkg::ST_OK;
            end
            shutdown_pkg::ST_OK: begin
                d.msg_valid = 1'b1;
                d.msg.kind  = shutdown_pkg::MSG_OK;
                d.msg.level = shutdown_pkg::LVL_NORMAL;
                d.fsm       = shutdown_pkg::ST_LOGOFF;
            end
            shutdown_pkg::ST_LOGOFF: begin
                if (logoff_done) begin
                    d.fsm = shutdown_pkg::ST_SAVE;
                end
            end
            shutdown_pkg::ST_SAVE: begin
                if (save_done) begin
                    d.fsm        = shutdown_pkg::ST_NOTICE;
                    d.data_saved = 1'b1;
                    if (q.save_cnt != 32'hffffffff) begin
                        d.save_cnt = q.save_cnt + 32'h1;
                    end
                end
            end
            shutdown_pkg::ST_NOTICE: begin
                d.msg_valid = 1'b1;
                d.msg.kind  = shutdown_pkg::MSG_SHUTDOWN_NOTICE;
                d.msg.level = shutdown_pkg::LVL_NORMAL;
                d.fsm       = shutdown_pkg::ST_OFF;
            end
            shutdown_pkg::ST_OFF: begin
                d.fsm = shutdown_pkg::ST_OFF;
            end
            default: begin
                d.fsm = shutdown_pkg::ST_OFF;
            end
        endcase

        // Emergency cut skips the save: volatile data is lost by design
        if (emerg_cut && (q.fsm != shutdown_pkg::ST_OFF)) begin
            d.fsm       = shutdown_pkg::ST_OFF;
            d.msg_valid = 1'b0;
        end

        d.logoff_req = d.fsm == shutdown_pkg::ST_LOGOFF;
        d.save_req   = d.fsm == shutdown_pkg::ST_SAVE;
        d.supply_en  = d.fsm != shutdown_pkg::ST_OFF;
        d.rtc_only   = !d.supply_en;
        d.wdog_out   = wdog_pulse && q.sync2 && d.supply_en;
        d.pullup_en  = d.supply_en;
        d.pin_oe     = d.supply_en ? 7'h7f : 7'h00;

        if (reg_req.rd) begin
            unique case (reg_req.addr)
                shutdown_pkg::CTRL_OFS: begin
                    d.rdata[shutdown_pkg::CTRL_ALERT_SET_BIT] = q.alert_setting;
                end
                shutdown_pkg::STATUS_OFS: begin
                    d.rdata[shutdown_pkg::STAT_STATE_LSB +: 4] = {1'b0, q.fsm};
                    d.rdata[shutdown_pkg::STAT_SUPPLY_BIT]     = q.supply_en;
                    d.rdata[shutdown_pkg::STAT_WINDOW_BIT]     = q.start_win;
                    d.rdata[shutdown_pkg::STAT_EMERG_BIT]      = !q.sync2;
                    d.rdata[shutdown_pkg::STAT_ECALL_BIT]      = emergency_call_active;
                    d.rdata[shutdown_pkg::STAT_BAT_LSB +: 3]   = q.bat_rep;
                    d.rdata[shutdown_pkg::STAT_BRD_LSB +: 3]   = q.brd_rep;
                    d.rdata[shutdown_pkg::STAT_SAVED_BIT]      = q.data_saved;
                    d.rdata[shutdown_pkg::STAT_LIMIT_BIT]      = q.save_cnt >= shutdown_pkg::SAVE_CYCLE_LIMIT;
                end
                shutdown_pkg::SAVE_COUNT_OFS: begin
                    d.rdata = q.save_cnt;
                end
                default: begin
                    d.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= shutdown_pkg::STATE_RESET;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign reg_rdata               = q.rdata;
    assign emergency_off_pullup_en = q.pullup_en;
    assign supply_wdog_pulse       = q.wdog_out;
    assign logoff_req              = q.logoff_req;
    assign save_req                = q.save_req;
    assign msg_valid               = q.msg_valid;
    assign msg                     = q.msg;
    assign logic_supply_en         = q.supply_en;
    assign internal_reset_n        = q.supply_en;
    assign rtc_only_mode           = q.rtc_only;
    assign pin_oe                  = q.pin_oe;

    // Checks stall with clk_en, so every |=> antecedent but a_off_stays demands it
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_ack_msg;
        msg_valid && (msg.kind == shutdown_pkg::MSG_POWER_DOWN_ACK) && clk_en && !emerg_cut;
    endsequence

    sequence s_ok_msg;
        msg_valid && (msg.kind == shutdown_pkg::MSG_OK);
    endsequence

    a_ack_then_ok: assert property (s_ack_msg |=> s_ok_msg)
        else $error("acknowledge not followed by OK");

    a_ok_then_logoff: assert property (s_ok_msg
        |-> logoff_req && (($past(q.fsm) == shutdown_pkg::ST_OK) || !$past(clk_en)))
        else $error("OK without log-off request");

    a_notice_saved: assert property ((msg_valid && (msg.kind == shutdown_pkg::MSG_SHUTDOWN_NOTICE))
        |-> q.data_saved && !logic_supply_en)
        else $error("notice before data saved");

    a_supply_drop_cause: assert property ($fell(logic_supply_en)
        |-> ($past(q.fsm) == shutdown_pkg::ST_NOTICE) || $past(emerg_cut))
        else $error("supply dropped without shutdown");

    a_off_pins_float: assert property (!logic_supply_en
        |-> (pin_oe == 7'h00) && !emergency_off_pullup_en && rtc_only_mode)
        else $error("pins driven while off");

    a_wdog_blocked: assert property ((!q.sync2 && clk_en) |=> !supply_wdog_pulse)
        else $error("watchdog passed while pin low");

    a_emerg_cut_off: assert property ((emerg_cut && clk_en) |=> !logic_supply_en && !internal_reset_n)
        else $error("terminal count did not cut supply");

    a_emerg_release: assert property ((q.sync2 && clk_en) |=> (q.emerg_cnt == 32'h0))
        else $error("counter not cleared on release");

    a_crit_shutdown: assert property ((crit_armed && (q.fsm == shutdown_pkg::ST_RUN) && clk_en)
        |=> (q.fsm == shutdown_pkg::ST_LOGOFF) || (q.fsm == shutdown_pkg::ST_ACK) ||
            (q.fsm == shutdown_pkg::ST_OFF))
        else $error("critical level did not start shutdown");

    a_ecall_inhibit: assert property ((emergency_call_active && (q.fsm == shutdown_pkg::ST_RUN) &&
        !undervoltage_detect && !wr_pd && !emerg_cut && clk_en) |=> (q.fsm == shutdown_pkg::ST_RUN))
        else $error("shutdown during emergency call");

    a_crit_presented: assert property ((is_crit(battery_temp_level) && bat_diff && alert_slot &&
        !emerg_cut && clk_en) |=> msg_valid && (msg.kind == shutdown_pkg::MSG_BATTERY_ALERT) &&
        (msg.level == $past(battery_temp_level)))
        else $error("critical battery alert not shown");

    a_warn_gated: assert property ((msg_valid && ((msg.kind == shutdown_pkg::MSG_BATTERY_ALERT) ||
        (msg.kind == shutdown_pkg::MSG_BOARD_ALERT)) && !is_crit(msg.level))
        |-> $past(q.alert_setting) || $past(q.start_win))
        else $error("warning shown while suppressed");

    a_board_tracked: assert property ((brd_diff && !bat_diff && alert_slot && !emerg_cut && clk_en)
        |=> (q.brd_rep == $past(board_temp_level)))
        else $error("board level not recorded");

    a_logoff_to_save: assert property ((logoff_req && logoff_done &&
        clk_en && !emerg_cut)
        |=> save_req && !logoff_req)
        else $error("no save after log-off");

    a_save_to_notice: assert property ((save_req && save_done &&
        clk_en && !emerg_cut)
        |=> q.data_saved && (q.fsm == shutdown_pkg::ST_NOTICE))
        else $error("no notice after save");

    a_uv_shutdown: assert property ((undervoltage_detect && !wr_pd &&
        (q.fsm == shutdown_pkg::ST_RUN) && !emerg_cut && clk_en)
        |=> logoff_req)
        else $error("undervoltage ignored");

    a_off_stays: assert property (!logic_supply_en
        |=> !logic_supply_en && !logoff_req && !save_req)
        else $error("off state left");

    a_wdog_passes: assert property ((wdog_pulse && q.sync2 &&
        (q.fsm == shutdown_pkg::ST_RUN) && clk_en)
        |=> supply_wdog_pulse)
        else $error("watchdog not forwarded");

    a_warn_setting: assert property ((bat_diff && alert_slot &&
        q.alert_setting && !emerg_cut && clk_en)
        |=> msg_valid && (msg.kind == shutdown_pkg::MSG_BATTERY_ALERT))
        else $error("warning hidden");

    a_emerg_silent: assert property ((emerg_cut && clk_en)
        |=> !msg_valid && !logoff_req && !save_req)
        else $error("cut still sequenced");

    a_ecall_resume: assert property (($fell(emergency_call_active) &&
        crit_armed && !wr_pd && (q.fsm == shutdown_pkg::ST_RUN) && clk_en)
        |=> logoff_req || !logic_supply_en)
        else $error("no shutdown after call");

endmodule : module_shutdown_control
`default_nettype wire

// *** dv/far_side_model.sv ***
// Baseband-side model: answers log-off and save requests, beats the watchdog.
// Assumes requests are levels on core_clk held until the matching done pulse.
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       logoff_req,
    input  wire logic       save_req,
    input  wire logic [3:0] delay,
    output logic            logoff_done,
    output logic            save_done,
    output logic            wdog_pulse
);
    logic [3:0] wait_q;
    logic [2:0] beat_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_q      <= 4'h0;
            beat_q      <= 3'h0;
            logoff_done <= 1'b0;
            save_done   <= 1'b0;
            wdog_pulse  <= 1'b0;
        end else begin
            beat_q      <= beat_q + 3'h1;
            wdog_pulse  <= (beat_q == 3'h7);
            // Restarts after each done; delay applies to both steps
            wait_q      <= ((logoff_req || save_req) && !(logoff_done || save_done)) ? wait_q + 4'h1 : 4'h0;
            logoff_done <= logoff_req && !logoff_done && (wait_q == delay);
            save_done   <= save_req && !save_done && (wait_q == delay);
        end
    end
endmodule : far_side_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the shutdown sequencer with a baseband-side model.
// Assumes short cut and start-window counts so the run stays brief.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [31:0] EMERG_P = 32'h00000014;
    localparam logic [31:0] WIN_P   = 32'h00000032;
    logic                   core_clk = 1'b0;
    logic                   sys_rst  = 1'b1;
    shutdown_pkg::reg_req_s reg_req  = '0;
    logic [31:0]            reg_rdata;
    logic                   host_low = 1'b0;
    logic                   emergency_off_n;
    logic                   emergency_off_pullup_en, wdog_pulse, supply_wdog_pulse;
    logic [2:0]             bat_lvl = 3'h0;
    logic [2:0]             brd_lvl = 3'h0;
    logic                   call = 1'b0;
    logic                   uv   = 1'b0;
    logic                   logoff_req, logoff_done, save_req, save_done, msg_valid;
    shutdown_pkg::msg_s     msg;
    logic                   logic_supply_en, internal_reset_n, rtc_only_mode;
    shutdown_pkg::pin_oe_s  pin_oe;
    logic [3:0]             far_delay = 4'h0;
    logic [31:0]            lfsr = 32'hedc261b1;
    logic [31:0]            rd;
    logic [2:0]             kq[$];
    logic [2:0]             lq[$];
    logic [2:0]             lvl;
    logic                   wd;
    int                     miscompares = 0;
    int                     check_count = 0;
    int                     cyc = 0;
    int                     n;
    // Open-drain line: host pulls low, otherwise the device pull-up or an external pull-down
    assign emergency_off_n = host_low ? 1'b0 : emergency_off_pullup_en;
    always #2 core_clk = ~core_clk;
    module_shutdown_control #(.EMERG_CUT_CYCLES_P(EMERG_P), .START_WINDOW_CYCLES_P(WIN_P)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .emergency_off_n(emergency_off_n), .emergency_off_pullup_en(emergency_off_pullup_en),
        .wdog_pulse(wdog_pulse), .supply_wdog_pulse(supply_wdog_pulse), .battery_temp_level(bat_lvl),
        .board_temp_level(brd_lvl), .emergency_call_active(call), .undervoltage_detect(uv),
        .logoff_req(logoff_req), .logoff_done(logoff_done), .save_req(save_req), .save_done(save_done),
        .msg_valid(msg_valid), .msg(msg), .logic_supply_en(logic_supply_en),
        .internal_reset_n(internal_reset_n), .rtc_only_mode(rtc_only_mode), .pin_oe(pin_oe));
    far_side_model u_far (.core_clk(core_clk), .sys_rst(sys_rst), .logoff_req(logoff_req),
        .save_req(save_req), .delay(far_delay), .logoff_done(logoff_done), .save_done(save_done),
        .wdog_pulse(wdog_pulse));
    function automatic logic [31:0] next_rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rnd
    function automatic logic [31:0] exp_stat(input logic [2:0] bat, input logic [2:0] brd, input logic win);
        return {17'h0, brd, 1'b0, bat, 2'b0, win, 1'b1, 4'h0};
    endfunction : exp_stat
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req <= '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        d = reg_rdata;
    endtask : reg_rd
    task automatic exp_msgs(input int cnt, input logic [8:0] ks);
        chk(kq.size(), cnt);
        for (int i = 0; i < cnt && i < kq.size(); i++) chk(kq[i], ks[8-3*i -: 3]);
        kq.delete();
        lq.delete();
    endtask : exp_msgs
    task automatic do_reset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        {host_low, call, uv, bat_lvl, brd_lvl} <= '0;
        lfsr = next_rnd(lfsr);
        far_delay <= lfsr[3:0];
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        kq.delete();
        lq.delete();
    endtask : do_reset
    task automatic wait_off(input int lim);
        n = 0;
        while (logic_supply_en !== 1'b0 && n < lim) begin
            tick(1);
            n++;
        end
        tick(1);
        chk(logic_supply_en, 1'b0);
        chk({rtc_only_mode, internal_reset_n, emergency_off_pullup_en}, 3'h4);
        chk({25'h0, pin_oe}, 32'h0);
    endtask : wait_off
    task automatic end_sim();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // Only the final notice may see the supply down
    always @(posedge core_clk) begin
        if (msg_valid === 1'b1) begin
            kq.push_back(msg.kind);
            lq.push_back(msg.level);
            chk(logic_supply_en, msg.kind != shutdown_pkg::MSG_SHUTDOWN_NOTICE);
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        do_reset();
        chk({25'h0, pin_oe}, 32'h7f);
        lfsr = next_rnd(lfsr);
        lvl = lfsr[0] ? shutdown_pkg::LVL_OVER_WARN : shutdown_pkg::LVL_UNDER_WARN;
        @(posedge core_clk) bat_lvl <= lvl;
        tick(4);
        chk(lq.size() ? lq[0] : 3'h5, lvl);
        exp_msgs(1, {shutdown_pkg::MSG_BATTERY_ALERT, 6'h0});
        @(posedge core_clk) bat_lvl <= 3'h0;
        tick(64);
        exp_msgs(1, {shutdown_pkg::MSG_BATTERY_ALERT, 6'h0});
        @(posedge core_clk) brd_lvl <= lvl;
        tick(4);
        exp_msgs(0, 9'h0);
        reg_rd(shutdown_pkg::STATUS_OFS, rd);
        chk(rd, exp_stat(3'h0, lvl, 1'b0));
        reg_wr(shutdown_pkg::CTRL_OFS, 32'h1);
        reg_rd(shutdown_pkg::CTRL_OFS, rd);
        chk(rd, 32'h1);
        reg_rd(8'h40, rd);
        chk(rd, 32'h0);
        @(posedge core_clk) {bat_lvl, brd_lvl} <= {lvl, 3'h0};
        tick(5);
        exp_msgs(2, {shutdown_pkg::MSG_BATTERY_ALERT, shutdown_pkg::MSG_BOARD_ALERT, 3'h0});
        $display("test alerts done");
        do_reset();
        reg_rd(shutdown_pkg::STATUS_OFS, rd);
        chk(rd, exp_stat(3'h0, 3'h0, 1'b1));
        reg_wr(shutdown_pkg::CTRL_OFS, 32'h2);
        wait_off(300);
        exp_msgs(3, {shutdown_pkg::MSG_POWER_DOWN_ACK, shutdown_pkg::MSG_OK, shutdown_pkg::MSG_SHUTDOWN_NOTICE});
        reg_rd(shutdown_pkg::SAVE_COUNT_OFS, rd);
        chk(rd, 32'h1);
        $display("test commanded done");
        do_reset();
        tick(60);
        @(posedge core_clk) brd_lvl <= shutdown_pkg::LVL_UNDER_CRIT;
        wait_off(300);
        chk(lq.size() ? lq[0] : 3'h5, shutdown_pkg::LVL_UNDER_CRIT);
        exp_msgs(2, {shutdown_pkg::MSG_BOARD_ALERT, shutdown_pkg::MSG_SHUTDOWN_NOTICE, 3'h0});
        $display("test thermal done");
        do_reset();
        @(posedge core_clk) {call, bat_lvl} <= {1'b1, shutdown_pkg::LVL_OVER_CRIT};
        tick(40);
        chk({logic_supply_en, logoff_req, save_req}, 3'h4);
        @(posedge core_clk) call <= 1'b0;
        wait_off(80);
        exp_msgs(2, {shutdown_pkg::MSG_BATTERY_ALERT, shutdown_pkg::MSG_SHUTDOWN_NOTICE, 3'h0});
        $display("test emergency call done");
        do_reset();
        @(posedge core_clk) uv <= 1'b1;
        wait_off(300);
        exp_msgs(1, {shutdown_pkg::MSG_SHUTDOWN_NOTICE, 6'h0});
        $display("test undervoltage done");
        do_reset();
        wd = 1'b0;
        for (int i = 0; i < 16; i++) begin
            tick(1);
            wd = wd | supply_wdog_pulse;
        end
        chk({wd, internal_reset_n}, 2'h3);
        @(posedge core_clk) host_low <= 1'b1;
        tick(10);
        @(posedge core_clk) host_low <= 1'b0;
        tick(6);
        chk(logic_supply_en, 1'b1);
        @(posedge core_clk) host_low <= 1'b1;
        n = 0;
        wd = 1'b0;
        while (logic_supply_en !== 1'b0 && n < 100) begin
            tick(1);
            n++;
            if (n > 3) wd = wd | supply_wdog_pulse;
        end
        chk(wd, 1'b0);
        chk(n > 10 && n <= EMERG_P, 1'b1);
        @(posedge core_clk) host_low <= 1'b0;
        tick(3);
        chk(emergency_off_pullup_en, 1'b0);
        exp_msgs(0, 9'h0);
        $display("test emergency off done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
